// ### rtl/fill_ramp_pkg.sv
// shared constants and types for the feedback warning and fill ramp block
package fill_ramp_pkg;

    // process values in milli-units, fill setpoint in micro-units
    typedef logic signed [31:0] val_t;
    typedef logic signed [47:0] fine_t;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] LOW_OFF = 8'h04;
    localparam logic [7:0] HIGH_OFF = 8'h08;
    localparam logic [7:0] IRAMP_OFF = 8'h0C;
    localparam logic [7:0] RATE_OFF = 8'h10;
    localparam logic [7:0] FILLED_OFF = 8'h14;
    localparam logic [7:0] FBMIN_OFF = 8'h18;
    localparam logic [7:0] REFMAX_OFF = 8'h1C;
    localparam logic [7:0] SP1_OFF = 8'h20;
    localparam logic [7:0] SP2_OFF = 8'h24;
    localparam logic [7:0] STAT_OFF = 8'h28;

    // control register fields
    localparam int CTRL_W = 8;
    localparam int CTRL_CLOSED = 0;
    localparam int CTRL_NORMAL = 1;
    localparam int CTRL_SPSEL = 2;
    localparam int CTRL_STOPFILL = 3;
    localparam int CTRL_LO_SIG = 4;
    localparam int CTRL_HI_SIG = 5;
    localparam int CTRL_LO_REL = 6;
    localparam int CTRL_HI_REL = 7;

    // limits and scales
    localparam val_t LIMIT_MAX = 32'sh3B9AC9FF;
    localparam val_t LIMIT_MIN = -32'sh3B9AC9FF;
    localparam logic [31:0] RATE_MAX = 32'h3B9AC9FF;
    localparam logic [15:0] IRAMP_MAX = 16'h0E10;
    localparam fine_t MILLI_PER_CENTI = 48'sh00000000000A;
    localparam fine_t MICRO_PER_MILLI = 48'sh0000000003E8;

    // fill ramp update period
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILL_TICK_NS = 1000000;
    localparam int FILL_TICK_CYCLES = FILL_TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 24;

    typedef enum logic [2:0] {
        FILL_IDLE,
        FILL_WAIT_MIN,
        FILL_RAMP,
        FILL_RUN,
        FILL_STOP
    } fill_e;

    typedef struct packed {
        logic start;
        val_t feedback;
        logic [15:0] out_freq;
        logic [15:0] ref_freq;
        logic [15:0] min_freq;
    } drive_in_s;

    typedef struct packed {
        fine_t setpoint;
        logic warn_low;
        logic warn_high;
        logic sig_warn;
        logic relay_warn;
        logic initial_ramp_sel;
        logic [15:0] initial_ramp_time;
        logic fill_active;
        logic fill_done;
    } drive_out_s;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic [CTRL_W-1:0] ctrl;
        val_t low;
        val_t high;
        logic [15:0] iramp;
        logic [31:0] rate;
        val_t filled;
        val_t fbmin;
        val_t refmax;
        val_t sp1;
        val_t sp2;
        logic eval;
        logic min_seen;
        logic [TICK_W-1:0] tick;
        fill_e fsm;
        drive_out_s out;
    } state_s;

    function automatic fine_t clampf(input fine_t v, input fine_t lo,
                                     input fine_t hi);
        clampf = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

endpackage

// ### rtl/fill_ramp.sv
// feedback limit warnings, initial ramp select and fill mode sequencer
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Flag low feedback warning while feedback is below the low limit.
// - Flag high feedback warning while feedback is above the high limit.
// - Hold warnings off during start ramp, stop ramp and standstill.
// - Evaluate warnings only after output frequency reached the reference.
// - Route active warnings to signal and relay outputs as configured.
// - Keep high limit between low limit and 999,999.999.
// - With initial ramp set, accelerate to minimum frequency on it.
// - Past minimum frequency, return to the normal ramp-up rate.
// - Initial ramp time 0.1 s to 360.0 s in 0.1 s steps.
// - Initial ramp of zero means off; off after reset.
// - Fill allowed only in closed loop, nonzero rate, normal selection.
// - Fill starts after start once minimum frequency is reached.
// - Fill samples feedback, then ramps setpoint toward filled setpoint.
// - Fill rate counts process units per second.
// - On filled, switch to the selected operating setpoint.
// - Fill rate 0.001 to 999999.999 units/s; off after reset.
// - Filled setpoint within minimum feedback and maximum reference, 0.01.
// - Optionally ramp the setpoint down at fill rate on stop.
// - Loop selection: 0 is open loop, 1 is closed loop.
module fill_ramp
    import fill_ramp_pkg::*;
#(
    parameter int TICK_CYCLES = FILL_TICK_CYCLES
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // drive side
    input wire drive_in_s din,
    output var drive_out_s dout
);

    localparam state_s ST_RST = '{
        low: LIMIT_MIN,
        high: LIMIT_MAX,
        fsm: FILL_IDLE,
        default: '0
    };
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    state_s r;
    state_s n;
    logic hready_q;
    logic hresp_q;

    logic fill_ok;
    logic tick_now;
    logic eval_next;
    logic min_next;
    logic stop_go;
    fine_t op_fine;
    fine_t target;
    fine_t floor_fine;
    fine_t fb_fine;
    fine_t wv;
    logic [7:0] ra;
    logic rd_hit;
    logic [31:0] rd;

    always_comb
    begin
        n = r;
        wv = fine_t'(signed'(hwdata));
        // data phase write; limits clamped as they are stored
        if (r.wr_pend)
        begin
            unique case (r.wr_addr)
                CTRL_OFF: n.ctrl = hwdata[CTRL_W-1:0];
                LOW_OFF: n.low = val_t'(clampf(wv, fine_t'(LIMIT_MIN),
                                               fine_t'(r.high)));
                HIGH_OFF: n.high = val_t'(clampf(wv, fine_t'(r.low),
                                                 fine_t'(LIMIT_MAX)));
                IRAMP_OFF: n.iramp = (hwdata > 32'(IRAMP_MAX)) ? IRAMP_MAX
                                     : hwdata[15:0];
                RATE_OFF: n.rate = (hwdata > RATE_MAX) ? RATE_MAX
                                   : hwdata;
                FILLED_OFF: n.filled = val_t'(clampf(wv * MILLI_PER_CENTI,
                                                     fine_t'(r.fbmin),
                                                     fine_t'(r.refmax)));
                FBMIN_OFF: n.fbmin = hwdata;
                REFMAX_OFF: n.refmax = hwdata;
                SP1_OFF: n.sp1 = hwdata;
                SP2_OFF: n.sp2 = hwdata;
                default: n.ctrl = r.ctrl;
            endcase
        end
        n.wr_pend = hready && hsel && htrans[1] && hwrite &&
                    (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
        n.wr_addr = haddr[7:0];

        // warning evaluation: armed once at reference, dropped by stop
        eval_next = din.start && (r.eval ||
                    (din.out_freq == din.ref_freq));
        n.eval = eval_next;
        n.out.warn_low = eval_next &&
                         (din.feedback < r.low);
        n.out.warn_high = eval_next &&
                          (din.feedback > r.high);
        n.out.sig_warn = (n.out.warn_low && n.ctrl[CTRL_LO_SIG]) ||
                         (n.out.warn_high && n.ctrl[CTRL_HI_SIG]);
        n.out.relay_warn = (n.out.warn_low && n.ctrl[CTRL_LO_REL]) ||
                           (n.out.warn_high && n.ctrl[CTRL_HI_REL]);

        // initial ramp only below the first arrival at minimum frequency
        min_next = din.start && (r.min_seen ||
                   (din.out_freq >= din.min_freq));
        n.min_seen = min_next;
        n.out.initial_ramp_sel = din.start && (n.iramp != 16'h0000) &&
                                 !min_next;
        n.out.initial_ramp_time = n.iramp;

        // fill sequencer
        fill_ok = n.ctrl[CTRL_CLOSED] && n.ctrl[CTRL_NORMAL] &&
                  (n.rate != 32'h00000000);
        tick_now = (r.tick == TICK_LAST);
        n.tick = tick_now ? '0 : r.tick + 1'b1;
        op_fine = fine_t'(n.ctrl[CTRL_SPSEL] ? n.sp2 : n.sp1) *
                  MICRO_PER_MILLI;
        target = fine_t'(n.filled) * MICRO_PER_MILLI;
        floor_fine = fine_t'(n.fbmin) * MICRO_PER_MILLI;
        fb_fine = fine_t'(din.feedback) * MICRO_PER_MILLI;
        stop_go = n.ctrl[CTRL_STOPFILL] && (n.rate != 32'h00000000);
        unique case (r.fsm)
            FILL_IDLE:
            begin
                n.out.setpoint = op_fine;
                if (din.start)
                begin
                    n.out.fill_done = 1'b0;
                    n.fsm = fill_ok ? FILL_WAIT_MIN : FILL_RUN;
                end
            end
            FILL_WAIT_MIN:
            begin
                n.out.setpoint = op_fine;
                if (!din.start)
                    n.fsm = FILL_IDLE;
                else if (din.out_freq >= din.min_freq)
                begin
                    n.out.setpoint = fb_fine;
                    n.fsm = FILL_RAMP;
                end
            end
            FILL_RAMP:
            begin
                if (!din.start)
                    n.fsm = stop_go ? FILL_STOP : FILL_IDLE;
                else if (din.feedback >= n.filled)
                begin
                    n.out.fill_done = 1'b1;
                    n.out.setpoint = op_fine;
                    n.fsm = FILL_RUN;
                end
                else if (tick_now)
                begin
                    // rate in milli-units/s equals micro-units per ms
                    if (r.out.setpoint + fine_t'(n.rate) > target)
                        n.out.setpoint = target;
                    else
                        n.out.setpoint = r.out.setpoint +
                                         fine_t'(n.rate);
                end
            end
            FILL_RUN:
            begin
                n.out.setpoint = op_fine;
                if (!din.start)
                    n.fsm = stop_go ? FILL_STOP : FILL_IDLE;
            end
            FILL_STOP:
            begin
                if (din.start)
                begin
                    n.out.fill_done = 1'b0;
                    n.fsm = fill_ok ? FILL_WAIT_MIN : FILL_RUN;
                end
                else if (r.out.setpoint <= floor_fine)
                    n.fsm = FILL_IDLE;
                else if (tick_now)
                begin
                    if (r.out.setpoint - fine_t'(n.rate) < floor_fine)
                        n.out.setpoint = floor_fine;
                    else
                        n.out.setpoint = r.out.setpoint -
                                         fine_t'(n.rate);
                end
            end
        endcase
        n.out.fill_active = (n.fsm == FILL_RAMP);

        // read data taken from post-write values, so no stale readback
        ra = haddr[7:0];
        rd_hit = hready && hsel && htrans[1] && !hwrite;
        unique case (ra)
            CTRL_OFF: rd = 32'(n.ctrl);
            LOW_OFF: rd = n.low;
            HIGH_OFF: rd = n.high;
            IRAMP_OFF: rd = 32'(n.iramp);
            RATE_OFF: rd = n.rate;
            FILLED_OFF: rd = n.filled;
            FBMIN_OFF: rd = n.fbmin;
            REFMAX_OFF: rd = n.refmax;
            SP1_OFF: rd = n.sp1;
            SP2_OFF: rd = n.sp2;
            STAT_OFF: rd = {21'h000000, 3'(r.fsm), r.eval, r.min_seen,
                            r.out.fill_done, r.out.fill_active,
                            r.out.relay_warn, r.out.sig_warn,
                            r.out.warn_high, r.out.warn_low};
            default: rd = 32'h00000000;
        endcase
        if ((haddr[31:8] != 24'h000000) || (haddr[1:0] != 2'h0))
            rd = 32'h00000000;
        n.hrdata = rd_hit ? rd : 32'h00000000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= ST_RST;
            hready_q <= 1'b0;
            hresp_q <= 1'b0;
        end
        else
        begin
            r <= n;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    assign hreadyout = hready_q;
    assign hresp = hresp_q;
    assign hrdata = r.hrdata;
    assign dout = r.out;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence seq_min_hit;
        r.fsm == FILL_WAIT_MIN && din.start &&
            din.out_freq >= din.min_freq;
    endsequence

    sequence seq_filled;
        r.fsm == FILL_RAMP && din.start && din.feedback >= r.filled;
    endsequence

    AST_LOW_WARN: assert property (
        (din.start && r.eval && din.feedback < r.low) |=> dout.warn_low)
        else $error("low feedback warning missing");

    AST_HIGH_WARN: assert property (
        (din.start && r.eval && din.feedback > r.high) |=> dout.warn_high)
        else $error("high feedback warning missing");

    AST_QUIET_STOP: assert property (
        !din.start |=> !dout.warn_low && !dout.warn_high &&
            !dout.sig_warn && !dout.relay_warn)
        else $error("warning active while stopping");

    AST_EVAL_WAIT: assert property (
        (din.start && !r.eval && din.out_freq != din.ref_freq)
            |=> !dout.warn_low && !dout.warn_high)
        else $error("warning before reference reached");

    AST_ROUTE: assert property (
        dout.warn_low && r.ctrl[CTRL_LO_SIG] |-> dout.sig_warn)
        else $error("low warning not routed");

    AST_HIGH_RANGE: assert property (
        r.high >= r.low && r.high <= LIMIT_MAX)
        else $error("high limit out of range");

    AST_INIT_END: assert property (
        (din.start && din.out_freq >= din.min_freq)
            |=> !dout.initial_ramp_sel [*2])
        else $error("initial ramp past minimum frequency");

    AST_INIT_OFF: assert property (
        dout.initial_ramp_sel |-> r.iramp != 16'h0000 &&
            r.iramp <= IRAMP_MAX)
        else $error("initial ramp used while off");

    AST_FILL_GATE: assert property (
        (r.fsm == FILL_IDLE && din.start && !r.ctrl[CTRL_CLOSED])
            |=> r.fsm == FILL_RUN)
        else $error("fill entered in open loop");

    AST_FILL_SAMPLE: assert property (
        seq_min_hit |=> r.fsm == FILL_RAMP &&
            dout.setpoint == fine_t'($past(din.feedback)) * MICRO_PER_MILLI)
        else $error("fill did not sample feedback");

    AST_FILL_DONE: assert property (
        seq_filled |=> dout.fill_done && r.fsm == FILL_RUN
            ##1 (dout.fill_done || r.fsm != FILL_RUN))
        else $error("fill completion not taken");

    AST_HIGH_ROUTE: assert property (
        dout.warn_high && r.ctrl[CTRL_HI_REL] |-> dout.relay_warn)
        else $error("high warning not routed");

    AST_WARN_ONE: assert property (
        !(dout.warn_low && dout.warn_high))
        else $error("both feedback warnings active");

    AST_INIT_SEL: assert property (
        (din.start && !r.wr_pend && r.iramp != 16'h0000 && !r.min_seen &&
            din.out_freq < din.min_freq) |=> dout.initial_ramp_sel)
        else $error("initial ramp not selected");

    sequence seq_stop_fill;
        r.fsm == FILL_RUN && !din.start && !r.wr_pend &&
            r.ctrl[CTRL_STOPFILL] && r.rate != 32'h00000000;
    endsequence

    AST_STOP_ENTRY: assert property (
        seq_stop_fill |=> r.fsm == FILL_STOP)
        else $error("stop fill ramp not entered");

    AST_FILL_HOLD: assert property (
        dout.fill_done && r.fsm == FILL_RUN |=> dout.fill_done)
        else $error("fill completion dropped while running");

endmodule

`default_nettype wire

// ### tb/motor_stage.sv
// motor power stage and pressure sensor model for the fill ramp bench
`timescale 1ns/1ps
`default_nettype none
module motor_stage
    import fill_ramp_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // commands and process state set by the bench
    input wire logic run,
    input wire val_t pressure,
    input wire logic [15:0] ref_freq,
    input wire logic [15:0] min_freq,
    // toward the block
    output var drive_in_s din
);
    logic [15:0] freq_reg;

    // one frequency step a cycle, so the block sees every ramp phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            freq_reg <= 16'h0;
        else if (run && freq_reg < ref_freq)
            freq_reg <= freq_reg + 16'h1;
        else if (freq_reg != 16'h0 && (!run || freq_reg > ref_freq))
            freq_reg <= freq_reg - 16'h1;
    end

    assign din = '{run, pressure, freq_reg, ref_freq, min_freq};
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the feedback warning and fill ramp block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import fill_ramp_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] ref_freq, min_freq;
    val_t pressure;
    drive_in_s din;
    drive_out_s dout;
    int err_total, checked;

    fill_ramp #(.TICK_CYCLES(4)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .din(din), .dout(dout));
    motor_stage u_motor (.hclk(hclk), .hresetn(hresetn), .run(run),
        .pressure(pressure), .ref_freq(ref_freq), .min_freq(min_freq),
        .din(din));

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task finish_test;
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [47:0] g, input logic [47:0] e);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // entered just after a rising edge; ready and data taken at rising edges
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk(hresp, 1'b0);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task wait_freq(input logic [15:0] f);
        for (int n = 0; n < 500 && din.out_freq !== f; n++)
            @(negedge hclk);
        chk(din.out_freq, f);
    endtask

    task stop_motor;
        @(posedge hclk);
        run <= 1'b0;
        wait_freq(16'h0);
        @(posedge hclk);
    endtask

    task t_regs;
        rd(LOW_OFF, unsigned'(LIMIT_MIN));
        rd(HIGH_OFF, LIMIT_MAX);
        rd(IRAMP_OFF, 32'h0);
        rd(RATE_OFF, 32'h0);
        rd(FILLED_OFF, 32'h0);
        rd(8'hFC, 32'h0);
        wr(LOW_OFF, 32'h3E8);
        wr(HIGH_OFF, 32'h1F4);
        rd(HIGH_OFF, 32'h3E8);
        wr(HIGH_OFF, 32'h7FFFFFFF);
        rd(HIGH_OFF, LIMIT_MAX);
        wr(IRAMP_OFF, 32'h1388);
        rd(IRAMP_OFF, 32'hE10);
        wr(RATE_OFF, 32'hFFFFFFFF);
        rd(RATE_OFF, RATE_MAX);
        wr(REFMAX_OFF, 32'h186A0);
        wr(FILLED_OFF, 32'h1F4);
        rd(FILLED_OFF, 32'h1388);
        wr(FILLED_OFF, 32'h1869F);
        rd(FILLED_OFF, 32'h186A0);
    endtask

    task t_warn;
        wr(HIGH_OFF, 32'h1388);
        wr(CTRL_OFF, 32'h50);
        pressure <= 32'sh1F4;
        run <= 1'b1;
        wait_freq(16'h14);
        chk(dout.warn_low, 1'b0);
        wait_freq(16'h28);
        repeat (3) @(negedge hclk);
        chk(dout.warn_low, 1'b1);
        chk(dout.sig_warn, 1'b1);
        chk(dout.relay_warn, 1'b1);
        @(posedge hclk);
        pressure <= 32'sh1770;
        repeat (3) @(negedge hclk);
        chk(dout.warn_high, 1'b1);
        chk(dout.warn_low, 1'b0);
        chk(dout.relay_warn, 1'b0);
        @(posedge hclk);
        run <= 1'b0;
        @(posedge hclk);
        @(negedge hclk);
        chk(dout.warn_high, 1'b0);
        stop_motor;
    endtask

    task t_iramp;
        wr(IRAMP_OFF, 32'h19);
        @(negedge hclk);
        chk(dout.initial_ramp_time, 16'h19);
        @(posedge hclk);
        run <= 1'b1;
        wait_freq(16'h5);
        chk(dout.initial_ramp_sel, 1'b1);
        wait_freq(16'h14);
        chk(dout.initial_ramp_sel, 1'b0);
        stop_motor;
        wr(IRAMP_OFF, 32'h0);
        run <= 1'b1;
        wait_freq(16'h5);
        chk(dout.initial_ramp_sel, 1'b0);
        stop_motor;
    endtask

    task t_refuse;
        for (int i = 0; i < 3; i++)
        begin
            wr(CTRL_OFF, (i == 0) ? 32'h1 : ((i == 1) ? 32'h2 : 32'h3));
            wr(RATE_OFF, (i == 2) ? 32'h0 : 32'h3E8);
            run <= 1'b1;
            wait_freq(16'h28);
            repeat (4) @(negedge hclk);
            chk(dout.fill_active, 1'b0);
            stop_motor;
        end
    endtask

    // stop ramping is enabled only on the last run: its descent is long
    task t_fill(input logic sel);
        fine_t sp;
        sp = sel ? 48'sh7A1200 : 48'sh6ACFC0;
        wr(RATE_OFF, 32'h3E8);
        wr(FILLED_OFF, 32'h1F4);
        wr(SP1_OFF, 32'h1B58);
        wr(SP2_OFF, 32'h1F40);
        wr(CTRL_OFF, {28'h0, sel, sel, 2'b11});
        pressure <= 32'sh3E8;
        run <= 1'b1;
        wait_freq(16'h5);
        chk(dout.fill_done, 1'b0);
        chk(dout.fill_active, 1'b0);
        for (int n = 0; n < 500 && dout.fill_active !== 1'b1; n++)
            @(negedge hclk);
        chk(dout.fill_active, 1'b1);
        chk(dout.setpoint, 48'shF4240);
        repeat (40) @(negedge hclk);
        chk(dout.setpoint, 48'shF6950);
        chk(dout.setpoint <= 48'sh4C4B40, 1'b1);
        @(posedge hclk);
        pressure <= 32'sh1388;
        for (int n = 0; n < 50 && dout.fill_done !== 1'b1; n++)
            @(negedge hclk);
        chk(dout.fill_done, 1'b1);
        chk(dout.setpoint, sp);
        @(posedge hclk);
        pressure <= 32'sh0;
        repeat (3) @(negedge hclk);
        chk(dout.fill_done, 1'b1);
        @(posedge hclk);
        run <= 1'b0;
        repeat (20) @(negedge hclk);
        if (sel)
            chk(dout.setpoint < sp, 1'b1);
        else
            chk(dout.setpoint, sp);
        stop_motor;
    endtask

    initial
    begin
        #100000;
        err_total++;
        finish_test;
    end

    initial
    begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        run = 1'b0;
        pressure = 32'sh0;
        ref_freq = 16'h28;
        min_freq = 16'hA;
        err_total = 0;
        checked = 0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_regs;
        t_warn;
        t_iramp;
        t_refuse;
        t_fill(1'b0);
        t_fill(1'b1);
        finish_test;
    end
endmodule
`default_nettype wire
